// ### verilog/fcd_pkg.sv
package fcd_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_ACCEL = 8'h14;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TOGGLING = 2;
  localparam int ST_REFUSED = 3;

  // ----------------------------------------
  // Flash bus widths and codes
  // ----------------------------------------
  localparam int AW = 23;
  localparam int DW = 16;
  localparam int BANK_LSB = 20;
  localparam int SECTOR_LSB = 12;
  localparam int TOGGLE_BIT = 6;
  localparam logic [11:0] A_555 = 12'h555;
  localparam logic [11:0] A_2AA = 12'h2aa;
  localparam logic [11:0] A_55 = 12'h055;
  localparam logic [7:0] D_UNLOCK1 = 8'haa;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_RESET = 8'hf0;
  localparam logic [7:0] D_IDENT = 8'h90;
  localparam logic [7:0] D_PROG = 8'ha0;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SECTOR = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hb0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_QUERY = 8'h98;
  localparam logic [7:0] D_BYPASS = 8'h20;
  localparam logic [7:0] D_EXIT2 = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int T_WE_LOW_NS = 100;
  localparam int T_ACCESS_NS = 300;
  localparam int SYNC_CYC = 3;
  localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;

  // ----------------------------------------
  // Commands and carriers
  // ----------------------------------------
  typedef enum logic [3:0] {
    C_READ, C_RESET, C_IDENT, C_PROGRAM, C_CHIP_ERASE, C_SECTOR_ERASE,
    C_SUSPEND, C_RESUME, C_QUERY, C_ACCEL_PROG, C_BYPASS_ENTRY,
    C_BYPASS_PROG, C_BYPASS_ERASE, C_BYPASS_QUERY, C_BYPASS_EXIT, C_POLL
  } fcd_cmd_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic protect_accelerate_pin;
  } fcd_pins_t;

  typedef struct packed {
    logic rd;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
  } fcd_step_t;

endpackage : fcd_pkg

// ### verilog/fcd_host.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module fcd_host
  import fcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fcd_pins_t pins,
  input wire logic [DW-1:0] dq_in
);

  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_READ} fcd_state_t;

  fcd_state_t state, next_state;
  fcd_cmd_t cmd, next_cmd;
  logic [2:0] step, next_step;
  logic [3:0] cnt, next_cnt;
  logic [AW-1:0] op_addr, next_op_addr;
  logic [DW-1:0] op_data, next_op_data;
  logic [DW-1:0] rd_last, next_rd_last;
  logic [DW-1:0] rd_prev, next_rd_prev;
  logic done, next_done;
  logic refused, next_refused;
  logic accel, next_accel;
  fcd_pins_t next_pins;
  logic [DW-1:0] s1, s2, s3, rd_stable, next_rd_stable;
  fcd_step_t cur;
  logic [2:0] n_steps;
  logic wr_en, rd_en, mapped, start;

  // ----------------------------------------
  // Sequence table
  // ----------------------------------------
  function automatic fcd_step_t seq(input fcd_cmd_t c, input logic [2:0] i,
                                    input logic [AW-1:0] ua, input logic [DW-1:0] ud);
    fcd_step_t s;
    logic [AW-1:0] hi;
    s = '0;
    hi = {ua[AW-1:SECTOR_LSB], 12'h000};
    // unlock cycles use low bits only
    s.a = {{(AW-12){1'b0}}, (i[0] ? A_2AA : A_555)};
    s.d = {8'h00, (i[0] ? D_UNLOCK2 : D_UNLOCK1)};
    case (c)
      // reads go only where software points
      C_READ: begin
        s.rd = 1'b1;
        s.a = ua;
      end
      C_RESET: s.d = {8'h00, D_RESET};
      C_IDENT: begin
        if (i == 3'd2) begin
          s.a = {ua[AW-1:BANK_LSB], {(BANK_LSB-12){1'b0}}, A_555};
          s.d = {8'h00, D_IDENT};
        end else if (i == 3'd3) begin
          // bank and offset from host address
          s.rd = 1'b1;
          s.a = ua;
        end
      end
      C_PROGRAM: begin
        if (i == 3'd2) begin
          s.d = {8'h00, D_PROG};
        end else if (i == 3'd3) begin
          s.a = ua;
          s.d = ud;
        end
      end
      C_CHIP_ERASE, C_SECTOR_ERASE: begin
        if (i == 3'd2) begin
          s.d = {8'h00, D_ERASE};
        end else if (i == 3'd5) begin
          s.a = (c == C_SECTOR_ERASE) ? hi : {{(AW-12){1'b0}}, A_555};
          s.d = {8'h00, (c == C_SECTOR_ERASE) ? D_SECTOR : D_CHIP};
        end else if (i >= 3'd3) begin
          s.a = {{(AW-12){1'b0}}, (i == 3'd4 ? A_2AA : A_555)};
          s.d = {8'h00, (i == 3'd4 ? D_UNLOCK2 : D_UNLOCK1)};
        end
      end
      // single-cycle suspend and resume at bank
      C_SUSPEND, C_RESUME: begin
        s.a = {ua[AW-1:BANK_LSB], {BANK_LSB{1'b0}}};
        s.d = {8'h00, (c == C_SUSPEND) ? D_SUSPEND : D_RESUME};
      end
      C_QUERY: begin
        s.a = {ua[AW-1:BANK_LSB], {(BANK_LSB-12){1'b0}}, A_55};
        s.d = {8'h00, D_QUERY};
      end
      C_ACCEL_PROG, C_BYPASS_PROG: begin
        s.a = (i == 3'd0) ? '0 : ua;
        s.d = (i == 3'd0) ? {8'h00, D_PROG} : ud;
      end
      C_BYPASS_ENTRY: begin
        if (i == 3'd2) begin
          s.d = {8'h00, D_BYPASS};
        end
      end
      C_BYPASS_ERASE: begin
        s.a = '0;
        s.d = {8'h00, (i == 3'd0) ? D_ERASE : D_CHIP};
      end
      C_BYPASS_QUERY: begin
        s.a = '0;
        s.d = {8'h00, D_QUERY};
      end
      C_BYPASS_EXIT: begin
        s.a = '0;
        s.d = {8'h00, (i == 3'd0) ? D_IDENT : D_EXIT2};
      end
      C_POLL: begin
        s.rd = 1'b1;
        s.a = ua;
      end
      default: s = '0;
    endcase
    return s;
  endfunction : seq

  always_comb begin
    case (cmd)
      C_READ, C_RESET, C_SUSPEND, C_RESUME, C_QUERY, C_BYPASS_QUERY: n_steps = 3'd1;
      C_ACCEL_PROG, C_BYPASS_PROG, C_BYPASS_ERASE, C_BYPASS_EXIT, C_POLL: n_steps = 3'd2;
      C_BYPASS_ENTRY: n_steps = 3'd3;
      C_IDENT, C_PROGRAM: n_steps = 3'd4;
      default: n_steps = 3'd6;
    endcase
  end

  assign cur = seq(cmd, step, op_addr, op_data);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign mapped = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_WDATA) ||
                  (paddr == REG_RDATA) || (paddr == REG_STATUS) || (paddr == REG_ACCEL);
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_en = psel && penable && !pwrite;
  assign start = wr_en && (paddr == REG_CMD) && (state == S_IDLE) &&
                 !((fcd_cmd_t'(pwdata[3:0]) == C_ACCEL_PROG) && !accel);

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        REG_CMD: prdata = {28'h000_0000, cmd};
        REG_ADDR: prdata = {{(32-AW){1'b0}}, op_addr};
        REG_WDATA: prdata = {16'h0000, op_data};
        REG_RDATA: prdata = {rd_prev, rd_last};
        REG_STATUS: prdata = {28'h000_0000, refused,
                              rd_prev[TOGGLE_BIT] ^ rd_last[TOGGLE_BIT],
                              done, state != S_IDLE};
        REG_ACCEL: prdata = {31'h0000_0000, accel};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_step = step;
    next_cnt = cnt;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_rd_last = rd_last;
    next_rd_prev = rd_prev;
    next_done = done;
    next_refused = refused;
    next_accel = accel;
    if (wr_en && paddr == REG_ADDR && state == S_IDLE) begin
      next_op_addr = pwdata[AW-1:0];
    end
    if (wr_en && paddr == REG_WDATA && state == S_IDLE) begin
      next_op_data = pwdata[DW-1:0];
    end
    if (wr_en && paddr == REG_ACCEL && state == S_IDLE) begin
      next_accel = pwdata[0];
    end
    if (wr_en && paddr == REG_STATUS) begin
      if (pwdata[ST_DONE]) next_done = 1'b0;
      if (pwdata[ST_REFUSED]) next_refused = 1'b0;
    end
    if (wr_en && paddr == REG_CMD && !start) begin
      next_refused = 1'b1;
    end
    case (state)
      S_IDLE: begin
        if (start) begin
          next_cmd = fcd_cmd_t'(pwdata[3:0]);
          next_step = 3'd0;
          next_state = S_SETUP;
        end
      end
      S_SETUP: begin
        next_cnt = 4'd0;
        next_state = cur.rd ? S_READ : S_STROBE;
      end
      S_STROBE: begin
        next_cnt = cnt + 4'd1;
        if (cnt == 4'(WE_LOW_CYC - 1)) next_state = S_HOLD;
      end
      S_HOLD, S_READ: begin
        next_cnt = cnt + 4'd1;
        if (state == S_HOLD || cnt == 4'(ACCESS_CYC - 1)) begin
          if (state == S_READ) begin
            next_rd_prev = rd_last;
            next_rd_last = rd_stable;
          end
          if (step == n_steps - 3'd1) begin
            next_state = S_IDLE;
            next_done = 1'b1;
          end else begin
            next_step = step + 3'd1;
            next_state = S_SETUP;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_comb begin
    next_pins = pins;
    // accelerate level held by software setting
    next_pins.protect_accelerate_pin = accel;
    next_pins.ce_n = 1'b1;
    next_pins.we_n = 1'b1;
    next_pins.oe_n = 1'b1;
    next_pins.dq_oe = 1'b0;
    case (next_state)
      S_SETUP: begin
        next_pins.addr = seq(next_cmd, next_step, next_op_addr, next_op_data).a;
        next_pins.dq_out = seq(next_cmd, next_step, next_op_addr, next_op_data).d;
        next_pins.ce_n = 1'b0;
        next_pins.dq_oe = !seq(next_cmd, next_step, next_op_addr, next_op_data).rd;
      end
      S_STROBE: begin
        next_pins.ce_n = 1'b0;
        next_pins.we_n = 1'b0;
        next_pins.dq_oe = 1'b1;
      end
      S_HOLD: next_pins.dq_oe = 1'b1;
      S_READ: begin
        next_pins.ce_n = 1'b0;
        next_pins.oe_n = 1'b0;
      end
      default: next_pins.dq_oe = 1'b0;
    endcase
  end

  // Read data synchroniser
  always_comb begin
    next_rd_stable = (s2 == s3) ? s3 : rd_stable;
  end

  always_ff @(posedge clk) begin
    s1 <= dq_in;
    s2 <= s1;
    s3 <= s2;
    if (rst) begin
      state <= S_IDLE;
      cmd <= C_READ;
      step <= 3'd0;
      cnt <= 4'd0;
      op_addr <= '0;
      op_data <= '0;
      rd_last <= '0;
      rd_prev <= '0;
      done <= 1'b0;
      refused <= 1'b0;
      accel <= 1'b0;
      rd_stable <= '0;
      pins <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                oe_n: 1'b1, protect_accelerate_pin: 1'b0};
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      step <= next_step;
      cnt <= next_cnt;
      op_addr <= next_op_addr;
      op_data <= next_op_data;
      rd_last <= next_rd_last;
      rd_prev <= next_rd_prev;
      done <= next_done;
      refused <= next_refused;
      accel <= next_accel;
      rd_stable <= next_rd_stable;
      pins <= next_pins;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_we_in_ce: assert property (@(posedge clk) disable iff (rst)
    !pins.we_n |-> !pins.ce_n && pins.dq_oe) else $error("we low outside chip select");
  a_addr_held: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.we_n) |=> $stable(pins.addr) && $stable(pins.dq_out) && pins.we_n)
    else $error("address or data moved around strobe");
  a_rd_wr_excl: assert property (@(posedge clk) disable iff (rst)
    !pins.oe_n |-> pins.we_n && !pins.dq_oe) else $error("read and write overlap");
  a_reset_code: assert property (@(posedge clk) disable iff (rst)
    !pins.we_n && cmd == C_RESET |-> pins.dq_out == 16'h00f0) else $error("bad reset code");
  a_unlock_first: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.we_n) && cmd == C_PROGRAM && step == 3'd0 |->
    pins.addr == 23'h000555 && pins.dq_out == 16'h00aa) else $error("bad first unlock");
  a_suspend_bank: assert property (@(posedge clk) disable iff (rst)
    !pins.we_n && cmd == C_SUSPEND |-> pins.dq_out == 16'h00b0 &&
    pins.addr[19:0] == 20'h00000) else $error("bad suspend cycle");
  a_start_busy: assert property (@(posedge clk) disable iff (rst)
    start |=> state == S_SETUP ##1 !pins.ce_n) else $error("command did not start");
  a_read_len: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.oe_n) |-> !pins.oe_n [*6] ##1 pins.oe_n) else $error("read length wrong");
  a_accel_hold: assert property (@(posedge clk) disable iff (rst)
    cmd == C_ACCEL_PROG && state != S_IDLE |-> pins.protect_accelerate_pin)
    else $error("accelerate pin dropped");

endmodule : fcd_host

// ### testbench/fcd_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Flash device model
// ----------------------------------------
module fcd_flash_model
  import fcd_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h005a, // Arbitrary code
  parameter logic [7:0] LOCK_BITS = 8'h80,
  parameter logic [15:0] QRY_WORD = 16'h00c3, // Arbitrary value
  parameter int PROG_READS = 2
)(
  input wire fcd_pins_t pins,
  output logic [DW-1:0] dq_in
);
  logic [DW-1:0] mem [0:255];
  logic [DW-1:0] pd;
  logic [DW-1:0] rdv;
  logic [AW-1:0] wa;
  logic [AW-1:0] pa;
  logic [1:0] step;
  logic ident, prog, susp, tog, arm, query;
  logic [7:0] d;
  int left;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    {step, ident, prog, susp, tog, arm, query} = '0;
    rdv = 16'h0;
    left = 0;
  end

  always @(negedge pins.we_n) wa = pins.addr;

  always @(posedge pins.we_n) begin
    if (pins.dq_oe === 1'b1) begin
      d = pins.dq_out[7:0];
      if (arm) begin
        pa = wa;
        pd = pins.dq_out;
        prog = 1'b1;
        left = PROG_READS;
        arm = 1'b0;
      end else if (d == D_RESET) begin
        ident = 1'b0;
        query = 1'b0;
        step = 0;
      end else if (d == D_SUSPEND && prog && !susp) begin
        susp = 1'b1;
      end else if (d == D_RESUME && susp) begin
        susp = 1'b0;
      end else if (prog && !susp) begin
        step = 0;
      end else if (step == 0 && d == D_UNLOCK1 && wa[11:0] == A_555) begin
        step = 1;
      end else if (step == 1 && d == D_UNLOCK2 && wa[11:0] == A_2AA) begin
        step = 2;
      end else if (step == 2 && d == D_IDENT && wa[11:0] == A_555) begin
        ident = 1'b1;
        step = 0;
      end else if (step == 2 && d == D_PROG && wa[11:0] == A_555) begin
        arm = 1'b1;
        step = 0;
      end else if (step == 0 && d == D_PROG && pins.protect_accelerate_pin === 1'b1) begin
        arm = 1'b1;
      end else if (step == 0 && d == D_QUERY && wa[11:0] == A_55 && !prog) begin
        query = 1'b1;
      end else begin
        step = 0;
      end
    end
  end

  always @(negedge pins.oe_n) begin
    if (query) begin
      rdv = QRY_WORD;
    end else if (ident) begin
      rdv = (pins.addr[7:0] == 8'h03) ? {8'h00, LOCK_BITS} :
            (pins.addr[7:0] == 8'h02) ? 16'h0000 : MFR_CODE;
    end else if (prog && !susp) begin
      tog = ~tog;
      rdv = {8'h00, ~pd[7], tog, 6'h00};
      left--;
      if (left == 0) begin
        mem[pa[7:0]] = pd;
        prog = 1'b0;
      end
    end else if (prog && pins.addr[22:12] == pa[22:12]) begin
      rdv = {8'h00, ~pd[7], tog, 6'h00};
    end else begin
      rdv = mem[pins.addr[7:0]];
    end
  end

  // Unselected bus shows inverse
  assign dq_in = (!pins.ce_n && !pins.oe_n) ? rdv : ~rdv;
endmodule : fcd_flash_model

// ### testbench/test_flash_command_decoder_suspend.sv
`timescale 1ns/1ps
module test_flash_command_decoder_suspend
  import fcd_pkg::*;
;
  localparam logic [15:0] MFR = 16'h005a; // Arbitrary code
  localparam logic [7:0] LOCK = 8'h80;
  localparam logic [15:0] QRY = 16'h00c3; // Arbitrary value
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  fcd_pins_t pins;
  logic [DW-1:0] dq_in;
  int err_count, compares, cyc;

  fcd_host fcd_host_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .dq_in(dq_in));
  fcd_flash_model #(.MFR_CODE(MFR), .LOCK_BITS(LOCK), .QRY_WORD(QRY),
    .PROG_READS(2))
    fcd_flash_model_inst (.pins(pins), .dq_in(dq_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task cmp(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  task run(input fcd_cmd_t c);
    int n;
    wr(REG_CMD, {28'h0, c});
    n = 0;
    r = 32'h0;
    while (r[ST_DONE] !== 1'b1 && n < 500) begin
      rd(REG_STATUS);
      n++;
    end
    cmp({31'h0, r[ST_DONE]}, 32'h1);
    wr(REG_STATUS, 32'h2);
  endtask : run

  task final_report();
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(REG_STATUS);
    cmp(r, 32'h0);
    rd(8'h20);
    cmp({31'h0, e}, 32'h1);
    wr(REG_ACCEL, 32'h1);
    rd(REG_ACCEL);
    cmp(r, 32'h1);
    wr(REG_ACCEL, 32'h0);
    $display("test registers done");
    wr(REG_ADDR, 32'h10);
    wr(REG_WDATA, 32'h1234);
    run(C_PROGRAM);
    run(C_POLL);
    rd(REG_RDATA);
    cmp(r, 32'h00c0_0080);
    rd(REG_STATUS);
    cmp(r, 32'h4);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, 32'h1234);
    $display("test program done");
    wr(REG_ADDR, 32'h1020);
    wr(REG_WDATA, 32'h00ab);
    run(C_PROGRAM);
    wr(REG_ADDR, 32'h0);
    run(C_SUSPEND);
    wr(REG_ADDR, 32'h10);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, 32'h1234);
    wr(REG_ADDR, 32'h1000);
    run(C_IDENT);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, {16'h0, MFR});
    wr(REG_ADDR, 32'h3);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, {24'h0, LOCK});
    wr(REG_ADDR, 32'h1002);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, 32'h0);
    run(C_RESET);
    wr(REG_ADDR, 32'h10);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, 32'h1234);
    run(C_RESUME);
    run(C_POLL);
    rd(REG_RDATA);
    cmp(r, 32'h0040_0000);
    wr(REG_ADDR, 32'h1020);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, 32'h00ab);
    $display("test suspend done");
    run(C_QUERY);
    wr(REG_ADDR, 32'h10);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, {16'h0, QRY});
    run(C_RESET);
    run(C_CHIP_ERASE);
    run(C_SECTOR_ERASE);
    run(C_BYPASS_ENTRY);
    run(C_BYPASS_PROG);
    run(C_BYPASS_ERASE);
    run(C_BYPASS_QUERY);
    run(C_BYPASS_EXIT);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, 32'h1234);
    wr(REG_ACCEL, 32'h1);
    wr(REG_ADDR, 32'h30);
    wr(REG_WDATA, 32'h5638);
    run(C_ACCEL_PROG);
    run(C_POLL);
    run(C_READ);
    rd(REG_RDATA);
    cmp({16'h0, r[15:0]}, 32'h5638);
    wr(REG_ACCEL, 32'h0);
    $display("test other commands done");
    wr(REG_CMD, {28'h0, C_ACCEL_PROG});
    rd(REG_STATUS);
    cmp(r, 32'h8);
    wr(REG_STATUS, 32'h8);
    rd(REG_STATUS);
    cmp(r, 32'h0);
    $display("test refuse done");
    final_report();
  end
endmodule : test_flash_command_decoder_suspend
